// ### common/dbcr_pkg.sv
/*
 * Shared constants and types for the bank command legality block: command codes,
 * bank states and cycle counts for the register read/write, activate, precharge
 * and exit delays at a 200 MHz command clock.
 * Assumes both ends run on the same clock and reset.
 */
package dbcr_pkg;

    localparam int unsigned NUM_BANKS = 8;
    localparam int unsigned BANK_W    = 3;
    localparam int unsigned DATA_W    = 16;
    localparam int unsigned CNT_W     = 8;
    localparam int unsigned BURST_LEN = 4;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned T_REG_READ_PS   = 10000;
    localparam int unsigned T_REG_WRITE_PS  = 25000;
    localparam int unsigned T_ACT_ACT_PS    = 10000;
    localparam int unsigned T_ACT_COL_PS    = 18000;
    localparam int unsigned T_PRECHARGE_PS  = 18000;
    localparam int unsigned T_EXIT_PS       = 7500;

    function automatic logic [7:0] ps_to_cyc(input int unsigned ps);
        int unsigned c;
        c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        if (c < 1) begin
            c = 1;
        end
        return c[7:0];
    endfunction : ps_to_cyc

    localparam logic [7:0] REG_READ_CYC   = ps_to_cyc(T_REG_READ_PS);
    localparam logic [7:0] REG_WRITE_CYC  = ps_to_cyc(T_REG_WRITE_PS);
    localparam logic [7:0] ACT_ACT_CYC    = ps_to_cyc(T_ACT_ACT_PS);
    localparam logic [7:0] ACT_COL_CYC    = ps_to_cyc(T_ACT_COL_PS);
    localparam logic [7:0] PRECHARGE_CYC  = ps_to_cyc(T_PRECHARGE_PS);
    localparam logic [7:0] EXIT_CYC       = ps_to_cyc(T_EXIT_PS);
    localparam logic [7:0] BURST_CYC      = 8'h04;

    localparam logic [7:0] RESET_MR_ADDR  = 8'h3f;
    localparam logic [DATA_W-1:0] MEM_RESET_VAL = 16'h0000;

    typedef enum logic [3:0] {
        DBCR_NOP, DBCR_ACT, DBCR_RD, DBCR_WR, DBCR_PRE, DBCR_PREA,
        DBCR_MRR, DBCR_MRW, DBCR_BT, DBCR_REF, DBCR_SREF
    } dbcr_cmd_e;

    typedef enum logic [3:0] {
        ST_POWER_ON, ST_RESETTING, ST_IDLE, ST_ROW_ACT, ST_ACTIVE, ST_READING,
        ST_WRITING, ST_PRECHARGING, ST_IDLE_MRR, ST_RST_MRR, ST_ACT_MRR,
        ST_MR_WRITING
    } dbcr_bank_e;

endpackage : dbcr_pkg

// ### common/dbcr_if.sv
/*
 * Command link between the memory controller end and the device end.
 * Assumes one shared clock; all signals are sampled on its rising edge.
 */
interface dbcr_if (
    input wire logic clk
);
    import dbcr_pkg::*;

    logic                  cke;
    dbcr_cmd_e             cmd;
    logic [BANK_W-1:0]     bank;
    logic                  auto_pre;
    logic [7:0]            mr_addr;
    logic                  wr_valid;
    logic [DATA_W-1:0]     wr_data;
    logic                  wr_mask;
    logic                  busy;

    modport ctrl (
        output cke, cmd, bank, auto_pre, mr_addr, wr_valid, wr_data, wr_mask,
        input  busy
    );
    modport dev (
        input  cke, cmd, bank, auto_pre, mr_addr, wr_valid, wr_data, wr_mask,
        output busy
    );
endinterface : dbcr_if

// ### hw/dbcr_device.sv
/*
 * Device end: per-bank state tracking, command legality check, write masking.
 * Assumes the controller end drives the link from flip-flops on the same clock.
 */
// Notes on behaviour
// - Refresh, self-refresh, register write need all idle
// - Burst terminate acts on current burst bank
// - Only no-operation during register read/write states
// - Register read ends after read time, returns
// - Register write ends after write time, idle
// - Keep activate spacing between different banks
// - Auto precharge on or off equally allowed
// - Precharge one or all; all need valid
// - Register read allowed while row activating
// - Register read allowed while precharging
// - After register read, state follows prior timers
// - Write only after read burst ends
// - Read only after write burst ends
// - Auto precharge frees other banks after timing; the device ignores auto_pre and leaves the bank active after the burst
// - Reset is register write, enters resetting
// - Reset only when all idle, no burst
// - Burst terminate only during a burst
// - Mask high skips storing data beat
// - Illegal sequence needs full reinitialisation
// - Rules apply only with clock enable high
// - Bank idle once precharge period elapsed
module dbcr_device (
    input  wire logic                     I_CLK,
    input  wire logic                     I_ARST_N,
    dbcr_if.dev                           link,
    output logic [dbcr_pkg::NUM_BANKS*4-1:0] O_BANK_STATE,
    output logic                          O_ILLEGAL,
    output logic                          O_NEED_REINIT,
    output logic [dbcr_pkg::DATA_W-1:0]   O_MEM_WORD,
    output logic                          O_MEM_WRITTEN
);
    import dbcr_pkg::*;

    typedef struct packed {
        dbcr_bank_e [NUM_BANKS-1:0]             st;
        dbcr_bank_e [NUM_BANKS-1:0]             ret;
        logic [NUM_BANKS-1:0][CNT_W-1:0]        tmr;
        logic [NUM_BANKS-1:0][CNT_W-1:0]        rtmr;
        logic [CNT_W-1:0]                       act_gap;
        logic [CNT_W-1:0]                       burst_cnt;
        logic [CNT_W-1:0]                       exit_cnt;
        logic [BANK_W-1:0]                      burst_bank;
        logic                                   burst_on;
        logic                                   cke_prev;
        logic                                   illegal;
        logic                                   reinit;
        logic [DATA_W-1:0]                      mem;
        logic                                   mem_wr;
    } dbcr_dev_s;

    dbcr_dev_s s_q;
    dbcr_dev_s s_d;

    function automatic logic all_idle(input dbcr_bank_e [NUM_BANKS-1:0] st);
        logic r;
        r = 1'b1;
        for (int i = 0; i < NUM_BANKS; i++) begin
            if (st[i] != ST_IDLE) begin
                r = 1'b0;
            end
        end
        return r;
    endfunction : all_idle

    function automatic logic can_pre(input dbcr_bank_e b);
        return (b == ST_ACTIVE) || (b == ST_IDLE) || (b == ST_PRECHARGING)
            || (b == ST_READING) || (b == ST_WRITING);
    endfunction : can_pre

    function automatic logic in_mr(input dbcr_bank_e b);
        return (b == ST_IDLE_MRR) || (b == ST_RST_MRR) || (b == ST_ACT_MRR)
            || (b == ST_MR_WRITING);
    endfunction : in_mr

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        logic       bad;
        logic       any_mr;
        logic       rules_on;
        dbcr_bank_e cur;
        int unsigned b;
        bad      = 1'b0;
        any_mr   = 1'b0;
        rules_on = 1'b0;
        s_d      = s_q;
        s_d.mem_wr   = 1'b0;
        s_d.cke_prev = link.cke;
        b   = int'(link.bank);
        cur = s_q.st[b];

        // Timers count down; a bank whose delay expires moves on.
        for (int i = 0; i < NUM_BANKS; i++) begin
            if (s_q.tmr[i] != '0) s_d.tmr[i] = s_q.tmr[i] - 1'b1;
            if (s_q.rtmr[i] != '0) s_d.rtmr[i] = s_q.rtmr[i] - 1'b1;
            any_mr = any_mr | in_mr(s_q.st[i]);
            if (s_q.tmr[i] == 8'h01) begin
                if (s_q.st[i] == ST_ROW_ACT) begin
                    s_d.st[i] = ST_ACTIVE;
                end else if (s_q.st[i] == ST_PRECHARGING) begin
                    s_d.st[i] = ST_IDLE;
                end else if (s_q.st[i] == ST_MR_WRITING) begin
                    s_d.st[i] = ST_IDLE;
                end
            end
            if (s_q.rtmr[i] == 8'h01 && in_mr(s_q.st[i]) && s_q.st[i] != ST_MR_WRITING) begin
                s_d.st[i] = s_q.ret[i];
                // A timer that ran out during the read settles the bank.
                if (s_q.ret[i] == ST_ROW_ACT && s_q.tmr[i] <= 8'h01) begin
                    s_d.st[i] = ST_ACTIVE;
                end else if (s_q.ret[i] == ST_PRECHARGING && s_q.tmr[i] <= 8'h01) begin
                    s_d.st[i] = ST_IDLE;
                end
            end
        end
        if (s_q.act_gap != '0) s_d.act_gap = s_q.act_gap - 1'b1;
        if (s_q.exit_cnt != '0) s_d.exit_cnt = s_q.exit_cnt - 1'b1;
        if (s_q.burst_cnt != '0) begin
            s_d.burst_cnt = s_q.burst_cnt - 1'b1;
            if (s_q.burst_cnt == 8'h01) begin
                s_d.burst_on = 1'b0;
                if (s_q.st[s_q.burst_bank] == ST_READING
                        || s_q.st[s_q.burst_bank] == ST_WRITING) begin
                    s_d.st[s_q.burst_bank] = ST_ACTIVE;
                end
            end
        end
        if (!link.cke) begin
            s_d.exit_cnt = EXIT_CYC;
        end
        rules_on = link.cke && s_q.cke_prev && s_q.exit_cnt == '0;

        if (rules_on) begin
            case (link.cmd)
                DBCR_NOP: begin
                end
                DBCR_ACT: begin
                    bad = any_mr || cur != ST_IDLE || s_q.act_gap != '0;
                    if (!bad) begin
                        s_d.st[b]   = ST_ROW_ACT;
                        s_d.tmr[b]  = ACT_COL_CYC;
                        s_d.act_gap = ACT_ACT_CYC;
                    end
                end
                DBCR_RD, DBCR_WR: begin
                    // Either auto precharge variant is judged the same way.
                    bad = any_mr || !(cur == ST_ACTIVE || cur == ST_READING
                        || cur == ST_WRITING)
                        || (s_q.burst_on && link.cmd == DBCR_WR
                            && s_q.st[s_q.burst_bank] == ST_READING)
                        || (s_q.burst_on && link.cmd == DBCR_RD
                            && s_q.st[s_q.burst_bank] == ST_WRITING);
                    if (!bad) begin
                        if (s_q.burst_on && s_q.burst_bank != link.bank) begin
                            s_d.st[s_q.burst_bank] = ST_ACTIVE;
                        end
                        s_d.st[b]      = (link.cmd == DBCR_RD) ? ST_READING : ST_WRITING;
                        s_d.burst_on   = 1'b1;
                        s_d.burst_bank = link.bank;
                        s_d.burst_cnt  = BURST_CYC;
                    end
                end
                DBCR_PRE, DBCR_PREA: begin
                    bad = any_mr;
                    for (int i = 0; i < NUM_BANKS; i++) begin
                        if (link.cmd == DBCR_PREA || i == b) begin
                            bad = bad | !can_pre(s_q.st[i]);
                        end
                    end
                    if (!bad) begin
                        for (int i = 0; i < NUM_BANKS; i++) begin
                            if (link.cmd == DBCR_PREA || i == b) begin
                                s_d.st[i]  = ST_PRECHARGING;
                                s_d.tmr[i] = PRECHARGE_CYC;
                            end
                        end
                        if (link.cmd == DBCR_PREA || s_q.burst_bank == link.bank) begin
                            s_d.burst_on  = 1'b0;
                            s_d.burst_cnt = '0;
                        end
                    end
                end
                DBCR_MRR: begin
                    bad = any_mr || !(cur == ST_IDLE || cur == ST_ACTIVE
                        || cur == ST_ROW_ACT || cur == ST_PRECHARGING
                        || cur == ST_RESETTING);
                    if (!bad) begin
                        s_d.ret[b]  = cur;
                        s_d.rtmr[b] = REG_READ_CYC;
                        s_d.st[b]   = (cur == ST_RESETTING) ? ST_RST_MRR
                                    : (cur == ST_IDLE) ? ST_IDLE_MRR : ST_ACT_MRR;
                    end
                end
                DBCR_MRW: begin
                    // Power-on takes only the reset write; a resetting device takes any other.
                    bad = any_mr || s_q.burst_on || !(all_idle(s_q.st)
                        || (s_q.st[0] == ST_POWER_ON && link.mr_addr == RESET_MR_ADDR)
                        || (s_q.st[0] == ST_RESETTING && link.mr_addr != RESET_MR_ADDR));
                    if (!bad) begin
                        for (int i = 0; i < NUM_BANKS; i++) begin
                            if (link.mr_addr == RESET_MR_ADDR) begin
                                s_d.st[i] = ST_RESETTING;
                            end else begin
                                s_d.st[i]  = ST_MR_WRITING;
                                s_d.tmr[i] = REG_WRITE_CYC;
                            end
                        end
                        if (link.mr_addr == RESET_MR_ADDR) begin
                            s_d.mem    = MEM_RESET_VAL;
                            s_d.reinit = 1'b0;
                        end
                    end
                end
                DBCR_BT: begin
                    bad = any_mr || !s_q.burst_on || link.bank != s_q.burst_bank;
                    if (!bad) begin
                        s_d.st[s_q.burst_bank] = ST_ACTIVE;
                        s_d.burst_on  = 1'b0;
                        s_d.burst_cnt = '0;
                    end
                end
                default: begin
                    bad = any_mr || s_q.burst_on || !all_idle(s_q.st);
                end
            endcase
        end

        s_d.illegal = bad;
        if (bad) begin
            s_d.reinit = 1'b1;
        end

        // Write beats are stored only when unmasked.
        if (link.wr_valid && !link.wr_mask && !s_q.reinit) begin
            s_d.mem    = link.wr_data;
            s_d.mem_wr = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            s_q <= '0;
            for (int i = 0; i < NUM_BANKS; i++) begin
                s_q.st[i]  <= ST_POWER_ON;
                s_q.ret[i] <= ST_IDLE;
            end
        end else begin
            s_q <= s_d;
        end
    end

    assign O_BANK_STATE  = s_q.st;
    assign O_ILLEGAL     = s_q.illegal;
    assign O_NEED_REINIT = s_q.reinit;
    assign O_MEM_WORD    = s_q.mem;
    assign O_MEM_WRITTEN = s_q.mem_wr;
    assign link.busy     = s_q.illegal;

endmodule : dbcr_device

// ### hw/dbcr_ctrl.sv
/*
 * Controller end: issues one user command at a time, holding it back until it
 * is legal by its own bank tracking (precharges and register reads are sent without a bank check), and inserts no-operation cycles otherwise.
 * Assumes a user side that holds a request until it is accepted.
 */
module dbcr_ctrl (
    input  wire logic                        I_CLK,
    input  wire logic                        I_ARST_N,
    dbcr_if.ctrl                             link,
    input  wire logic                        I_REQ,
    input  wire dbcr_pkg::dbcr_cmd_e         I_CMD,
    input  wire logic [dbcr_pkg::BANK_W-1:0] I_BANK,
    input  wire logic                        I_AUTO_PRE,
    input  wire logic [7:0]                  I_MR_ADDR,
    input  wire logic [dbcr_pkg::DATA_W-1:0] I_WR_DATA,
    input  wire logic                        I_WR_MASK,
    output logic                             O_ACCEPT,
    output logic                             O_DEV_ERR
);
    import dbcr_pkg::*;

    typedef struct packed {
        logic [NUM_BANKS-1:0]                open;
        logic [NUM_BANKS-1:0][CNT_W-1:0]     busy_t;
        logic [CNT_W-1:0]                    act_gap;
        logic [CNT_W-1:0]                    hold;
        logic [CNT_W-1:0]                    burst;
        logic [CNT_W-1:0]                    beats;
        logic                                burst_wr;
        logic [BANK_W-1:0]                   burst_bank;
        dbcr_cmd_e                           cmd;
        logic [BANK_W-1:0]                   bank;
        logic                                auto_pre;
        logic [7:0]                          mr_addr;
        logic [DATA_W-1:0]                   wr_data;
        logic                                wr_mask;
        logic                                accept;
        logic                                err;
    } dbcr_ctl_s;

    dbcr_ctl_s s_q;
    dbcr_ctl_s s_d;

    always_comb begin
        logic ok;
        logic quiet;
        ok    = 1'b0;
        quiet = 1'b1;
        s_d   = s_q;
        s_d.cmd    = DBCR_NOP;
        s_d.accept = 1'b0;
        s_d.err    = s_q.err | link.busy;
        for (int i = 0; i < NUM_BANKS; i++) begin
            if (s_q.busy_t[i] != '0) begin
                s_d.busy_t[i] = s_q.busy_t[i] - 1'b1;
                quiet = 1'b0;
            end
        end
        if (s_q.act_gap != '0) s_d.act_gap = s_q.act_gap - 1'b1;
        if (s_q.burst != '0) s_d.burst = s_q.burst - 1'b1;
        if (s_q.beats != '0) s_d.beats = s_q.beats - 1'b1;
        if (s_q.hold != '0) begin
            s_d.hold = s_q.hold - 1'b1;
        end else if (I_REQ && !s_q.accept) begin
            case (I_CMD)
                DBCR_ACT: ok = !s_q.open[I_BANK] && s_q.busy_t[I_BANK] == '0
                    && s_q.act_gap == '0;
                DBCR_RD, DBCR_WR: ok = s_q.open[I_BANK] && s_q.busy_t[I_BANK] == '0
                    && (s_q.burst == '0 || s_q.burst_wr == (I_CMD == DBCR_WR));
                DBCR_BT: ok = s_q.burst != '0 && I_BANK == s_q.burst_bank;
                DBCR_PRE, DBCR_PREA, DBCR_MRR: ok = 1'b1;
                default: ok = s_q.open == '0 && quiet && s_q.burst == '0;
            endcase
            if (ok) begin
                s_d.cmd      = I_CMD;
                s_d.bank     = I_BANK;
                s_d.auto_pre = I_AUTO_PRE;
                s_d.mr_addr  = I_MR_ADDR;
                s_d.accept   = 1'b1;
                case (I_CMD)
                    DBCR_ACT: begin
                        s_d.open[I_BANK]   = 1'b1;
                        s_d.busy_t[I_BANK] = ACT_COL_CYC;
                        s_d.act_gap        = ACT_ACT_CYC;
                    end
                    DBCR_RD, DBCR_WR: begin
                        s_d.burst      = BURST_CYC;
                        s_d.beats      = (I_CMD == DBCR_WR) ? BURST_CYC : 8'h00;
                        s_d.burst_wr   = (I_CMD == DBCR_WR);
                        s_d.burst_bank = I_BANK;
                        s_d.wr_data    = I_WR_DATA;
                        s_d.wr_mask    = I_WR_MASK;
                        if (I_AUTO_PRE) begin
                            s_d.open[I_BANK]   = 1'b0;
                            s_d.busy_t[I_BANK] = BURST_CYC + PRECHARGE_CYC;
                        end
                    end
                    DBCR_BT: begin
                        s_d.burst = '0;
                        s_d.beats = '0;
                    end
                    DBCR_PRE, DBCR_PREA: begin
                        for (int i = 0; i < NUM_BANKS; i++) begin
                            if (I_CMD == DBCR_PREA || i == int'(I_BANK)) begin
                                s_d.open[i]   = 1'b0;
                                s_d.busy_t[i] = PRECHARGE_CYC;
                            end
                        end
                        s_d.burst = '0;
                    end
                    DBCR_MRR: s_d.hold = REG_READ_CYC;
                    DBCR_MRW: s_d.hold = REG_WRITE_CYC;
                    default: s_d.hold = '0;
                endcase
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            s_q     <= '0;
            s_q.cmd <= DBCR_NOP;
        end else begin
            s_q <= s_d;
        end
    end

    // Clock enable stays high; power-down is outside this block.
    assign link.cke      = 1'b1;
    assign link.cmd      = s_q.cmd;
    assign link.bank     = s_q.bank;
    assign link.auto_pre = s_q.auto_pre;
    assign link.mr_addr  = s_q.mr_addr;
    assign link.wr_valid = s_q.beats != '0;
    assign link.wr_data  = s_q.wr_data;
    assign link.wr_mask  = s_q.wr_mask;
    assign O_ACCEPT      = s_q.accept;
    assign O_DEV_ERR     = s_q.err;

endmodule : dbcr_ctrl

// ### testbench/dbcr_properties.sv
/* Link assertions for the bank command block.
   Assumes one clock and the active-low reset shared by both ends. */
module dbcr_properties (
    input wire logic                 clk,
    input wire logic                 I_ARST_N,
    input wire logic                 cke,
    input wire dbcr_pkg::dbcr_cmd_e  cmd,
    input wire logic [7:0]           mr_addr,
    input wire logic                 wr_valid,
    input wire logic                 busy
);
    timeunit 1ns;
    timeprecision 1ps;
    import dbcr_pkg::*;
    logic [2:0] rd_left_q;
    logic [2:0] wr_left_q;
    // Counts the cycles left in the burst that the last read or write began.
    always_ff @(posedge clk or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            rd_left_q <= 3'h0;
            wr_left_q <= 3'h0;
        end else begin
            rd_left_q <= (cmd == DBCR_RD) ? 3'h3 : (cmd != DBCR_NOP) ? 3'h0 : rd_left_q - 3'(|rd_left_q);
            wr_left_q <= (cmd == DBCR_WR) ? 3'h3 : (cmd != DBCR_NOP) ? 3'h0 : wr_left_q - 3'(|wr_left_q);
        end
    end
    default clocking @(posedge clk);
    endclocking
    default disable iff (!I_ARST_N);
    mrr_quiet_a: assert property (cmd == DBCR_MRR |=> cmd == DBCR_NOP)
        else $error("command during register read");
    mrw_quiet_a: assert property (
        cmd == DBCR_MRW && mr_addr != RESET_MR_ADDR |=> (cmd == DBCR_NOP) [*4])
        else $error("command during register write");
    act_gap_a: assert property (cmd == DBCR_ACT |=> cmd != DBCR_ACT)
        else $error("activates too close");
    no_error_a: assert property (!busy)
        else $error("device flagged an illegal command");
    bt_burst_a: assert property (cmd == DBCR_BT |-> (rd_left_q | wr_left_q) != 3'h0)
        else $error("burst terminate outside a burst");
    wr_after_rd_a: assert property (cmd == DBCR_WR |-> rd_left_q == 3'h0)
        else $error("write inside a read burst");
    rd_after_wr_a: assert property (cmd == DBCR_RD |-> wr_left_q == 3'h0)
        else $error("read inside a write burst");
    wr_beats_a: assert property (cmd == DBCR_WR |-> ##[0:1] wr_valid)
        else $error("write without data beats");
    refresh_idle_a: assert property (
        cmd inside {DBCR_REF, DBCR_SREF} |-> (rd_left_q | wr_left_q) == 3'h0)
        else $error("refresh during a burst");
    cke_on_a: assert property (cmd != DBCR_NOP |-> cke && $past(cke))
        else $error("command without clock enable");
endmodule : dbcr_properties

// ### testbench/testbench.sv
/* Bench for the bank command block: both ends joined by their link, driven
   through the controller's user side. Assumes a 5 ns clock. */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import dbcr_pkg::*;
    logic        clk, arst_n, req, ap, mask, accept, dev_err, reinit, illegal, written;
    dbcr_cmd_e   cmd;
    logic [2:0]  bank;
    logic [7:0]  addr;
    logic [15:0] data, mem_word;
    logic [31:0] bank_st;
    int          fails, compares;
    dbcr_if u_dbcr_if (.clk(clk));
    dbcr_device u_dbcr_device (.I_CLK(clk), .I_ARST_N(arst_n), .link(u_dbcr_if),
        .O_BANK_STATE(bank_st), .O_ILLEGAL(illegal), .O_NEED_REINIT(reinit),
        .O_MEM_WORD(mem_word), .O_MEM_WRITTEN(written));
    dbcr_ctrl u_dbcr_ctrl (.I_CLK(clk), .I_ARST_N(arst_n), .link(u_dbcr_if), .I_REQ(req),
        .I_CMD(cmd), .I_BANK(bank), .I_AUTO_PRE(ap), .I_MR_ADDR(addr), .I_WR_DATA(data),
        .I_WR_MASK(mask), .O_ACCEPT(accept), .O_DEV_ERR(dev_err));
    dbcr_properties u_dbcr_properties (.clk(clk), .I_ARST_N(arst_n), .cke(u_dbcr_if.cke),
        .cmd(u_dbcr_if.cmd), .mr_addr(u_dbcr_if.mr_addr), .wr_valid(u_dbcr_if.wr_valid),
        .busy(u_dbcr_if.busy));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic idle(input int n);
        req = 1'b0;
        repeat (n) @(negedge clk);
    endtask : idle
    // Holds one request until the controller accepts it; idle releases it.
    task automatic issue(input dbcr_cmd_e c, input logic [2:0] b = 3'h0, input logic [7:0] a = 8'h00,
                         input logic [15:0] d = 16'h0000, input logic m = 1'b0, input logic p = 1'b0);
        int n;
        n = 0;
        cmd = c;
        bank = b;
        addr = a;
        data = d;
        mask = m;
        ap = p;
        req = 1'b1;
        @(negedge clk);
        while (accept !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        check("accept", 32'h1, {31'h0, accept});
    endtask : issue
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        end_of_test();
    end
    initial begin
        {arst_n, req, ap, mask, bank, addr, data} = '0;
        cmd = DBCR_NOP;
        repeat (3) @(negedge clk);
        arst_n = 1'b1;
        idle(5);
        issue(DBCR_MRW, 3'h0, RESET_MR_ADDR);
        idle(1);
        check("reset states", {NUM_BANKS{ST_RESETTING}}, bank_st);
        issue(DBCR_MRR, 3'h0, 8'h05);
        idle(1);
        check("bank0 reading", ST_RST_MRR, bank_st[3:0]);
        idle(3);
        check("bank0 back", ST_RESETTING, bank_st[3:0]);
        issue(DBCR_MRW, 3'h0, 8'h01);
        idle(8);
        check("bank0 idle", ST_IDLE, bank_st[3:0]);
        $display("test register access done");
        issue(DBCR_ACT, 3'h1);
        issue(DBCR_ACT, 3'h2);
        issue(DBCR_MRR, 3'h2, 8'h05);
        idle(8);
        check("bank2 active", ST_ACTIVE, bank_st[11:8]);
        $display("test activate done");
        issue(DBCR_WR, 3'h1, 8'h00, 16'h5a5a);
        issue(DBCR_WR, 3'h1, 8'h00, 16'h1234, 1'b1);
        idle(8);
        check("masked word", 16'h5a5a, mem_word);
        issue(DBCR_RD, 3'h1);
        issue(DBCR_BT, 3'h1);
        issue(DBCR_WR, 3'h2, 8'h00, 16'h0f0f, 1'b0, 1'b1);
        idle(1);
        check("beat stored", 32'h1, {31'h0, written});
        issue(DBCR_RD, 3'h1, 8'h00, 16'h0000, 1'b0, 1'b1);
        idle(8);
        check("stored word", 16'h0f0f, mem_word);
        $display("test bursts done");
        issue(DBCR_PRE, 3'h1);
        issue(DBCR_MRR, 3'h1, 8'h05);
        idle(12);
        check("bank1 idle", ST_IDLE, bank_st[7:4]);
        issue(DBCR_PREA);
        idle(12);
        check("all idle", {NUM_BANKS{ST_IDLE}}, bank_st);
        issue(DBCR_REF);
        idle(12);
        check("reinit", 32'h0, {31'h0, reinit});
        check("illegal flag", 32'h0, {31'h0, illegal});
        check("device error", 32'h0, {31'h0, dev_err});
        $display("test precharge and refresh done");
        end_of_test();
    end
endmodule : testbench
